// *** asp_pkg.sv ***
/*
  Constants and types shared by the serial port top, its receive FIFO and the testbench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package asp_pkg;

  // register addresses on the processor's special-function space
  localparam logic [15:0] ASP_ADDR_MODE   = 16'hff70;
  localparam logic [15:0] ASP_ADDR_DIV    = 16'hff71;
  localparam logic [15:0] ASP_ADDR_TXB    = 16'hff72;
  localparam logic [15:0] ASP_ADDR_RXB    = 16'hff73;
  localparam logic [15:0] ASP_ADDR_TXSTAT = 16'hff74;
  localparam logic [15:0] ASP_ADDR_ERR    = 16'hff75;
  localparam logic [15:0] ASP_ADDR_P1     = 16'hff01;
  localparam logic [15:0] ASP_ADDR_P1DIR  = 16'hff21;

  // serial_mode_reg field positions
  localparam int ASP_POS_PORT_ON  = 7;
  localparam int ASP_POS_TX_EN    = 6;
  localparam int ASP_POS_RX_EN    = 5;
  localparam int ASP_POS_PAR_HI   = 4;
  localparam int ASP_POS_PAR_LO   = 3;
  localparam int ASP_POS_CHAR_LEN = 2;
  localparam int ASP_POS_STOP_LEN = 1;

  // tx_status_reg and error register field positions
  localparam int ASP_POS_BUSY     = 0;
  localparam int ASP_POS_FULL     = 1;
  localparam int ASP_POS_OVERRUN  = 0;
  localparam int ASP_POS_FRAMING  = 1;
  localparam int ASP_POS_PARITY   = 2;

  // port 1 pin positions of the serial functions
  localparam int ASP_POS_TXPIN    = 3;
  localparam int ASP_POS_RXPIN    = 2;

  // values after reset, and the port 1 direction bits forced to one on every direction write
  localparam logic [7:0] ASP_RST_MODE  = 8'h00;
  localparam logic [7:0] ASP_RST_DIV   = 8'h10;
  localparam logic [7:0] ASP_RST_P1DIR = 8'hff;
  localparam logic [7:0] ASP_RST_P1    = 8'h00;
  localparam logic [7:0] ASP_P1DIR_FIX = 8'he1;

  // smallest usable bit time in core clocks
  localparam logic [7:0] ASP_MIN_DIV   = 8'h04;

  // receive FIFO shape
  localparam int ASP_FIFO_W = 8;
  localparam int ASP_FIFO_D = 8;

  typedef enum logic [4:0] {
    ASP_IDLE  = 5'b00001,
    ASP_START = 5'b00010,
    ASP_DATA  = 5'b00100,
    ASP_PAR   = 5'b01000,
    ASP_STOP  = 5'b10000
  } asp_state_t;

endpackage : asp_pkg

// *** asp_fifo_if.sv ***
/*
  Valid/ready carrier between the receiver and its FIFO, both sides of the buffer.
  Assumes the owner of the interface drives the producer and consumer ends.
*/
`timescale 1ns/1ps
interface asp_fifo_if #(
  parameter int W = 8
);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;

  modport user (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
  modport buffer (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
endinterface : asp_fifo_if

// *** asp_fifo.sv ***
/*
  Flip-flop FIFO with valid/ready on both sides, first word shown on the read side.
  Assumes one clock shared with the user and a clock enable that freezes it.
*/
`timescale 1ns/1ps
module asp_fifo
  import asp_pkg::*;
#(
  parameter int W = ASP_FIFO_W,
  parameter int D = ASP_FIFO_D
)(
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  asp_fifo_if.buffer port_if
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full  = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign push  = port_if.wvalid && !full;
  assign pop   = port_if.rready && !empty;

  assign port_if.wready = !full;
  assign port_if.rvalid = !empty;
  assign port_if.rdata  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge core_clk_in)
  begin
    if (ce_in && push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= port_if.wdata;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else if (ce_in)
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  a_fifo_no_overfill : assert property (@(posedge core_clk_in) disable iff (rst_in)
    full |=> (wr_ptr_r == $past(wr_ptr_r)) || !full)
    else $error("fifo pointer moved while full");

endmodule : asp_fifo

// *** asp_serial_port.sv ***
/*
  Asynchronous serial port with double-buffered transmit, receive FIFO and port 1 pin muxing.
  Assumes a processor special-function port with byte writes and per-bit write mask,
  and port 1 pins resolved outside from the output and enable signals.
*/
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic [7:0]  cpu_wdata_in,
  input  wire logic [7:0]  cpu_wmask_in,
  input  wire logic        cpu_we_in,
  input  wire logic        cpu_re_in,
  output logic      [7:0]  cpu_rdata_out,
  input  wire logic [7:0]  p1_pin_in,
  output logic      [7:0]  p1_pin_out,
  output logic      [7:0]  p1_pin_oe_out,
  output logic             tx_done_irq_out
);

  logic [7:0] serial_mode_reg_r;
  logic [7:0] baud_divider_reg_r;
  logic [7:0] port1_direction_r;
  logic [7:0] port1_latch_r;
  logic [2:0] err_r;
  logic [7:0] tx_holding_buffer_r;
  logic       holding_full_flag_r;
  logic [7:0] tx_shifter_r;
  logic       tx_line_r;
  logic       tx_par_r;
  logic [7:0] tx_cnt_r;
  logic [3:0] tx_bits_r;
  asp_state_t tx_st_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_cnt_r;
  logic [3:0] rx_bits_r;
  asp_state_t rx_st_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [7:0] pin_s3_r;
  logic [7:0] pin_lvl_r;
  logic       rx_wvalid_r;
  logic [7:0] rx_wdata_r;
  logic       par_err_set;
  logic       frm_err_set;
  logic       ovr_err_set;

  asp_fifo_if #(.W(ASP_FIFO_W)) rx_if ();

  logic       port_on;
  logic       tx_run;
  logic       rx_run;
  logic       par_on;
  logic [3:0] nbits;
  logic [7:0] div_eff;
  logic [7:0] half_eff;
  logic       wr_hit_txb;
  logic       tx_load;
  logic       shifter_busy_flag;
  logic       tx_stop_last;
  logic [7:0] tx_byte_m;
  logic [7:0] rx_byte;
  logic       rx_lvl;

  assign port_on  = serial_mode_reg_r[ASP_POS_PORT_ON];
  assign tx_run   = port_on && serial_mode_reg_r[ASP_POS_TX_EN];
  assign rx_run   = port_on && serial_mode_reg_r[ASP_POS_RX_EN];
  assign par_on   = serial_mode_reg_r[ASP_POS_PAR_HI];
  assign nbits    = serial_mode_reg_r[ASP_POS_CHAR_LEN] ? 4'h8 : 4'h7;
  assign div_eff  = (baud_divider_reg_r < ASP_MIN_DIV) ? ASP_MIN_DIV : baud_divider_reg_r;
  assign half_eff = {1'b0, div_eff[7:1]};
  assign rx_lvl   = pin_lvl_r[ASP_POS_RXPIN];
  assign shifter_busy_flag = (tx_st_r != ASP_IDLE);
  assign wr_hit_txb = cpu_we_in && (cpu_addr_in == ASP_ADDR_TXB) && tx_run;
  assign tx_stop_last = (tx_st_r == ASP_STOP) && (tx_cnt_r == 8'h00)
                        && (!serial_mode_reg_r[ASP_POS_STOP_LEN] || (tx_bits_r != 4'h0));
  // next byte taken straight from an idle shifter or at the end of the last stop bit
  assign tx_load  = tx_run && holding_full_flag_r && ((tx_st_r == ASP_IDLE) || tx_stop_last);
  assign tx_byte_m = serial_mode_reg_r[ASP_POS_CHAR_LEN] ? tx_holding_buffer_r : {1'b0, tx_holding_buffer_r[6:0]};
  assign rx_byte  = serial_mode_reg_r[ASP_POS_CHAR_LEN] ? rx_sh_r : {1'b0, rx_sh_r[7:1]};

  // pin input synchronisers, a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      always_ff @(posedge core_clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          pin_s1_r[gi]      <= 1'b1;
          pin_s2_r[gi]      <= 1'b1;
          pin_s3_r[gi]      <= 1'b1;
          pin_lvl_r[gi]     <= 1'b1;
          p1_pin_out[gi]    <= 1'b0;
          p1_pin_oe_out[gi] <= 1'b0;
        end
        else if (ce_in)
        begin
          pin_s1_r[gi] <= p1_pin_in[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi])
          begin
            pin_lvl_r[gi] <= pin_s3_r[gi];
          end
          // serial output only while transmit runs, else the port latch
          if ((gi == ASP_POS_TXPIN) && tx_run)
          begin
            p1_pin_out[gi] <= tx_line_r;
          end
          else
          begin
            p1_pin_out[gi] <= port1_latch_r[gi];
          end
          p1_pin_oe_out[gi] <= !port1_direction_r[gi];
        end
      end
    end
  endgenerate

  // register writes, masked per bit
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      serial_mode_reg_r  <= ASP_RST_MODE;
      baud_divider_reg_r <= ASP_RST_DIV;
      port1_direction_r  <= ASP_RST_P1DIR;
      port1_latch_r      <= ASP_RST_P1;
    end
    else if (ce_in && cpu_we_in)
    begin
      if (cpu_addr_in == ASP_ADDR_MODE)
      begin
        serial_mode_reg_r <= (serial_mode_reg_r & ~cpu_wmask_in) | (cpu_wdata_in & cpu_wmask_in);
      end
      else if (cpu_addr_in == ASP_ADDR_DIV)
      begin
        baud_divider_reg_r <= (baud_divider_reg_r & ~cpu_wmask_in) | (cpu_wdata_in & cpu_wmask_in);
      end
      else if (cpu_addr_in == ASP_ADDR_P1DIR)
      begin
        port1_direction_r <= ((port1_direction_r & ~cpu_wmask_in) | (cpu_wdata_in & cpu_wmask_in))
                             | ASP_P1DIR_FIX;
      end
      else if (cpu_addr_in == ASP_ADDR_P1)
      begin
        port1_latch_r <= (port1_latch_r & ~cpu_wmask_in) | (cpu_wdata_in & cpu_wmask_in);
      end
    end
  end

  // register reads, one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cpu_rdata_out <= 8'h00;
    end
    else if (ce_in && cpu_re_in)
    begin
      if (cpu_addr_in == ASP_ADDR_MODE)
      begin
        cpu_rdata_out <= serial_mode_reg_r;
      end
      else if (cpu_addr_in == ASP_ADDR_DIV)
      begin
        cpu_rdata_out <= baud_divider_reg_r;
      end
      else if (cpu_addr_in == ASP_ADDR_TXB)
      begin
        cpu_rdata_out <= tx_holding_buffer_r;
      end
      else if (cpu_addr_in == ASP_ADDR_RXB)
      begin
        cpu_rdata_out <= rx_if.rvalid ? rx_if.rdata : 8'h00;
      end
      else if (cpu_addr_in == ASP_ADDR_TXSTAT)
      begin
        cpu_rdata_out <= {6'h00, holding_full_flag_r, shifter_busy_flag};
      end
      else if (cpu_addr_in == ASP_ADDR_ERR)
      begin
        cpu_rdata_out <= {5'h00, err_r};
      end
      else if (cpu_addr_in == ASP_ADDR_P1DIR)
      begin
        cpu_rdata_out <= port1_direction_r;
      end
      else if (cpu_addr_in == ASP_ADDR_P1)
      begin
        cpu_rdata_out <= (pin_lvl_r & port1_direction_r) | (port1_latch_r & ~port1_direction_r);
      end
      else
      begin
        cpu_rdata_out <= 8'h00;
      end
    end
  end

  // holding buffer; a write in the load cycle wins the flag
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_holding_buffer_r <= 8'h00;
      holding_full_flag_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_hit_txb)
      begin
        tx_holding_buffer_r <= cpu_wdata_in;
      end
      if (!tx_run)
      begin
        holding_full_flag_r <= 1'b0;
      end
      else if (wr_hit_txb)
      begin
        holding_full_flag_r <= 1'b1;
      end
      else if (tx_load)
      begin
        holding_full_flag_r <= 1'b0;
      end
    end
  end

  // transmit shifter
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_st_r         <= ASP_IDLE;
      tx_shifter_r    <= 8'h00;
      tx_line_r       <= 1'b1;
      tx_par_r        <= 1'b0;
      tx_cnt_r        <= 8'h00;
      tx_bits_r       <= 4'h0;
      tx_done_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_done_irq_out <= tx_stop_last;
      if (!tx_run)
      begin
        tx_st_r   <= ASP_IDLE;
        tx_line_r <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_st_r      <= ASP_START;
        tx_shifter_r <= tx_byte_m;
        tx_par_r     <= serial_mode_reg_r[ASP_POS_PAR_LO] ? ~^tx_byte_m : ^tx_byte_m;
        tx_line_r    <= 1'b0;
        tx_cnt_r     <= div_eff - 8'h01;
        tx_bits_r    <= 4'h0;
      end
      else if (tx_cnt_r != 8'h00)
      begin
        tx_cnt_r <= tx_cnt_r - 8'h01;
      end
      else
      begin
        tx_cnt_r <= div_eff - 8'h01;
        case (tx_st_r)
          ASP_START:
          begin
            tx_st_r   <= ASP_DATA;
            tx_line_r <= tx_shifter_r[0];
          end
          ASP_DATA:
          begin
            tx_shifter_r <= {1'b0, tx_shifter_r[7:1]};
            if (tx_bits_r == nbits - 4'h1)
            begin
              tx_bits_r <= 4'h0;
              tx_st_r   <= par_on ? ASP_PAR : ASP_STOP;
              tx_line_r <= par_on ? tx_par_r : 1'b1;
            end
            else
            begin
              tx_bits_r <= tx_bits_r + 4'h1;
              tx_line_r <= tx_shifter_r[1];
            end
          end
          ASP_PAR:
          begin
            tx_st_r   <= ASP_STOP;
            tx_line_r <= 1'b1;
          end
          ASP_STOP:
          begin
            if (tx_stop_last)
            begin
              tx_st_r <= ASP_IDLE;
            end
            else
            begin
              tx_bits_r <= 4'h1;
            end
          end
          default:
          begin
            tx_st_r <= ASP_IDLE;
          end
        endcase
      end
    end
  end

  // receiver; start found on the stable pin level, samples at mid-bit
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_st_r     <= ASP_IDLE;
      rx_sh_r     <= 8'h00;
      rx_cnt_r    <= 8'h00;
      rx_bits_r   <= 4'h0;
      rx_wvalid_r <= 1'b0;
      rx_wdata_r  <= 8'h00;
    end
    else if (ce_in)
    begin
      rx_wvalid_r <= 1'b0;
      if (!rx_run)
      begin
        rx_st_r <= ASP_IDLE;
      end
      else if (rx_st_r == ASP_IDLE)
      begin
        if (!rx_lvl)
        begin
          rx_st_r  <= ASP_START;
          rx_cnt_r <= half_eff;
        end
      end
      else if (rx_cnt_r != 8'h00)
      begin
        rx_cnt_r <= rx_cnt_r - 8'h01;
      end
      else
      begin
        rx_cnt_r <= div_eff - 8'h01;
        case (rx_st_r)
          ASP_START:
          begin
            rx_st_r   <= rx_lvl ? ASP_IDLE : ASP_DATA;
            rx_bits_r <= 4'h0;
          end
          ASP_DATA:
          begin
            rx_sh_r <= {rx_lvl, rx_sh_r[7:1]};
            if (rx_bits_r == nbits - 4'h1)
            begin
              rx_st_r <= par_on ? ASP_PAR : ASP_STOP;
            end
            else
            begin
              rx_bits_r <= rx_bits_r + 4'h1;
            end
          end
          ASP_PAR:
          begin
            rx_st_r <= ASP_STOP;
          end
          ASP_STOP:
          begin
            rx_st_r     <= ASP_IDLE;
            rx_wvalid_r <= rx_if.wready;
            rx_wdata_r  <= rx_byte;
          end
          default:
          begin
            rx_st_r <= ASP_IDLE;
          end
        endcase
      end
    end
  end

  assign par_err_set = rx_run && (rx_st_r == ASP_PAR) && (rx_cnt_r == 8'h00)
                       && (rx_lvl != (serial_mode_reg_r[ASP_POS_PAR_LO] ? ~^rx_byte : ^rx_byte));
  assign frm_err_set = rx_run && (rx_st_r == ASP_STOP) && (rx_cnt_r == 8'h00) && !rx_lvl;
  assign ovr_err_set = rx_run && (rx_st_r == ASP_STOP) && (rx_cnt_r == 8'h00) && !rx_if.wready;

  // error flags clear on read, a new error in the read cycle wins
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      err_r <= 3'h0;
    end
    else if (ce_in)
    begin
      err_r <= ((cpu_re_in && (cpu_addr_in == ASP_ADDR_ERR)) ? 3'h0 : err_r)
               | {par_err_set, frm_err_set, ovr_err_set};
    end
  end

  assign rx_if.wdata  = rx_wdata_r;
  assign rx_if.wvalid = rx_wvalid_r;
  assign rx_if.rready = ce_in && cpu_re_in && (cpu_addr_in == ASP_ADDR_RXB);

  asp_fifo #(.W(ASP_FIFO_W), .D(ASP_FIFO_D)) u_rx_fifo (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .port_if     (rx_if.buffer)
  );

  sequence s_pending;
    holding_full_flag_r && !shifter_busy_flag && tx_run;
  endsequence
  sequence s_loaded;
    shifter_busy_flag && !holding_full_flag_r && !tx_line_r;
  endsequence

  a_port_stop_release : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    (!port_on && !serial_mode_reg_r[ASP_POS_TX_EN] && !serial_mode_reg_r[ASP_POS_RX_EN])
    |=> p1_pin_out[ASP_POS_TXPIN] == $past(port1_latch_r[ASP_POS_TXPIN]))
    else $error("tx pin not released to port latch");
  a_tx_write_start : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    (wr_hit_txb && !holding_full_flag_r && !shifter_busy_flag) |=> s_pending ##1 s_loaded)
    else $error("written byte did not start a frame");
  a_holding_freed : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    ($rose(shifter_busy_flag) && !$past(wr_hit_txb)) |-> !holding_full_flag_r)
    else $error("holding buffer not freed at shift start");
  a_done_pulse : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    tx_stop_last |=> tx_done_irq_out ##1 !tx_done_irq_out)
    else $error("completion pulse missing or too long");
  a_busy_holds : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in || !tx_run)
    $rose(shifter_busy_flag) |-> shifter_busy_flag [*8])
    else $error("busy flag dropped inside a frame");
  a_flag_sequence : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    s_pending |=> s_loaded)
    else $error("full/busy pair skipped a step");
  a_rx_sample_timing : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    (rx_st_r == ASP_DATA) && ($past(rx_st_r) == ASP_START) |-> rx_cnt_r == div_eff - 8'h01)
    else $error("receive bit timer not loaded from divider");
  a_dir_write : assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
    (cpu_we_in && (cpu_addr_in == ASP_ADDR_P1DIR)) |=> port1_direction_r ==
      ((($past(port1_direction_r) & ~$past(cpu_wmask_in)) | ($past(cpu_wdata_in) & $past(cpu_wmask_in)))
       | ASP_P1DIR_FIX))
    else $error("direction write mask wrong");

endmodule : asp_serial_port

// *** asp_node_model.sv ***
/*
  Far serial node: sends 8N1 frames on its line and collects frames seen on the port's line.
  Assumes the bench resolves the port's transmit pin with a pull-up and shares the core clock.
*/
`timescale 1ns/1ps
module asp_node_model #(
  parameter int DIV = 8
)(
  input  wire logic core_clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_q[$];
  logic [7:0] sh;

  initial line_out = 1'b1;

  // start, 8 data lsb first, one stop, exact bit time
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge core_clk_in);
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (DIV) @(posedge core_clk_in);
    end
  endtask : send_byte

  // mid-bit sampling from the falling start edge
  initial
  begin
    forever
    begin
      @(posedge core_clk_in);
      if (line_in === 1'b0)
      begin
        repeat (DIV / 2) @(posedge core_clk_in);
        for (int i = 0; i < 8; i++)
        begin
          repeat (DIV) @(posedge core_clk_in);
          sh[i] = line_in;
        end
        repeat (DIV) @(posedge core_clk_in);
        got_q.push_back(sh);
      end
    end
  end
endmodule : asp_node_model

// *** testbench.sv ***
/*
  Self-checking bench for the serial port: register bus tasks, queue model, far node.
  Assumes the port runs with ce_in high except in the clock enable freeze check, and one 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import asp_pkg::*;
  localparam int DIV = 8;
  logic        core_clk_in;
  logic        rst_in;
  logic        ce_in;
  logic        cpu_we_in;
  logic        cpu_re_in;
  logic        tx_done_irq_out;
  logic        node_line;
  logic        tx_line;
  logic [15:0] cpu_addr_in;
  logic [7:0]  cpu_wdata_in;
  logic [7:0]  cpu_wmask_in;
  logic [7:0]  cpu_rdata_out;
  logic [7:0]  p1_pin_out;
  logic [7:0]  p1_pin_oe_out;
  logic [7:0]  p1_rand;
  logic [7:0]  v;
  logic [7:0]  b;
  logic [7:0]  tx_exp[$];
  logic [7:0]  rx_exp[$];
  int          n_mismatch;
  int          check_count;
  int          n_done;

  // pull-up on the transmit pin while undriven
  assign tx_line = p1_pin_oe_out[3] ? p1_pin_out[3] : 1'b1;

  asp_serial_port u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_wmask_in(cpu_wmask_in), .cpu_we_in(cpu_we_in), .cpu_re_in(cpu_re_in),
    .cpu_rdata_out(cpu_rdata_out), .p1_pin_in({p1_rand[7:3], node_line, p1_rand[1:0]}),
    .p1_pin_out(p1_pin_out), .p1_pin_oe_out(p1_pin_oe_out), .tx_done_irq_out(tx_done_irq_out));
  asp_node_model #(.DIV(DIV)) u_node (.core_clk_in(core_clk_in), .line_in(tx_line), .line_out(node_line));

  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
    if (tx_done_irq_out === 1'b1)
      n_done <= n_done + 1;

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge core_clk_in);
    cpu_addr_in  <= a;
    cpu_wdata_in <= d;
    cpu_wmask_in <= m;
    cpu_we_in    <= 1'b1;
    @(posedge core_clk_in);
    cpu_we_in    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    cpu_addr_in <= a;
    cpu_re_in   <= 1'b1;
    p1_rand     <= 8'($urandom);
    @(posedge core_clk_in);
    cpu_re_in   <= 1'b0;
    #1;
    d = cpu_rdata_out;
  endtask : rd

  // poll transmit status with a bounded count
  task automatic wait_stat(input logic [7:0] want);
    logic [7:0] s;
    s = 8'h5a;
    for (int i = 0; i < 400 && s !== want; i++)
      rd(ASP_ADDR_TXSTAT, s);
    check(s, want, "tx status");
  endtask : wait_stat

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial
  begin
    #100000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    n_done = 0;
    rst_in = 1'b1;
    cpu_we_in = 1'b0;
    cpu_re_in = 1'b0;
    cpu_addr_in = 16'h0000;
    cpu_wdata_in = 8'h00;
    cpu_wmask_in = 8'h00;
    ce_in = 1'b1;
    p1_rand = 8'($urandom(73258));
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(ASP_ADDR_P1DIR, v);
    check(v, 8'hff, "direction reset");
    check(p1_pin_oe_out, 8'h00, "oe after reset");
    rd(ASP_ADDR_MODE, v);
    check(v, 8'h00, "mode reset");
    rd(16'hff40, v);
    check(v, 8'h00, "unmapped read");
    $display("test reset done");
    wr(ASP_ADDR_DIV, 8'(DIV), 8'hff);
    wr(ASP_ADDR_MODE, 8'h04, 8'hff);
    wr(ASP_ADDR_MODE, 8'h84, 8'hff);
    wr(ASP_ADDR_MODE, 8'he4, 8'hff);
    wr(ASP_ADDR_P1, 8'h00, 8'hff);
    wr(ASP_ADDR_P1DIR, 8'h04, 8'hff);
    rd(ASP_ADDR_P1DIR, v);
    check(v, 8'he5, "byte write direction");
    check(p1_pin_oe_out, 8'h1a, "oe byte");
    wr(ASP_ADDR_P1DIR, 8'h10, 8'h10);
    rd(ASP_ADDR_P1DIR, v);
    check(v, 8'hf5, "bit write direction");
    check(p1_pin_oe_out, 8'h0a, "oe bit");
    $display("test config done");
    fork
      for (int i = 0; i < 9; i++)
      begin
        rx_exp.push_back(8'($urandom));
        u_node.send_byte(rx_exp[i]);
      end
      begin
        wait_stat(8'h00);
        for (int k = 0; k < 2; k++)
        begin
          b = 8'($urandom);
          tx_exp.push_back(b);
          wr(ASP_ADDR_TXB, b, 8'hff);
        end
        rd(ASP_ADDR_TXSTAT, v);
        check(v, 8'h03, "full and busy");
        wait_stat(8'h01);
        wait_stat(8'h00);
        tx_exp.push_back(8'($urandom));
        wr(ASP_ADDR_TXB, tx_exp[2], 8'hff);
        wait_stat(8'h00);
      end
    join
    repeat (DIV * 2) @(posedge core_clk_in);
    check(8'(n_done), 8'h03, "completion pulses");
    check(8'(u_node.got_q.size()), 8'h03, "frames seen");
    for (int i = 0; i < 3; i++)
      check(u_node.got_q[i], tx_exp[i], "sent byte");
    $display("test transmit done");
    rd(ASP_ADDR_ERR, v);
    check(v, 8'h01, "overrun on full fifo");
    for (int i = 0; i < 8; i++)
    begin
      rd(ASP_ADDR_RXB, v);
      check(v, rx_exp[i], "received byte");
    end
    rd(ASP_ADDR_ERR, v);
    check(v, 8'h00, "errors cleared by read");
    $display("test receive done");
    // 7 data bits, even parity, two stops: the node sees parity as its bit 7
    wr(ASP_ADDR_MODE, 8'hf2, 8'hff);
    b = 8'($urandom);
    wr(ASP_ADDR_TXB, b, 8'hff);
    wait_stat(8'h00);
    check(u_node.got_q[3], {^b[6:0], b[6:0]}, "parity frame");
    check(8'(n_done), 8'h04, "completion pulse 11-bit");
    $display("test parity done");
    wr(ASP_ADDR_P1, 8'h08, 8'h08);
    wr(ASP_ADDR_MODE, 8'h00, 8'hff);
    wr(ASP_ADDR_TXB, 8'h55, 8'hff);
    rd(ASP_ADDR_TXSTAT, v);
    check(v, 8'h00, "write ignored while stopped");
    check({7'h00, p1_pin_out[3]}, 8'h01, "pin back to latch");
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    wr(ASP_ADDR_P1DIR, 8'h00, 8'hff);
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    rd(ASP_ADDR_P1DIR, v);
    check(v, 8'hf5, "write frozen by clock enable");
    $display("test stop done");
    final_report();
  end
endmodule : testbench
